// ---- pkg/port_pins_defs.svh ----
`ifndef PORT_PINS_DEFS_SVH
`define PORT_PINS_DEFS_SVH

// Port geometry
`define PORT_W 8
`define ADDR_W 16
// Internal data memory ends here; higher addresses go outside
`define INT_MEM_TOP 16'h0fff
// Reset value of an output-only port
`define OUT_PORT_RST 8'h00
// Reset value of the input-only port sample
`define IN_PORT_RST 8'h00
// Pull-up select reset: all off
`define PULLUP_RST 8'h00
// Minimum reset pulse, ns, and clock period, ns
`define RST_MIN_NS 50
`define CLK_PERIOD_NS 10
`define RST_MIN_CYC ((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- pkg/port_pins_pkg.sv ----
package port_pins_pkg;
	typedef enum logic [1:0] {
		XM_IDLE,
		XM_ADDR,
		XM_DATA
	} xmem_state_e;

	typedef logic [7:0] byte_t;
	typedef logic [15:0] addr_t;
endpackage

// ---- verilog/ext_bus_seq.sv ----
`timescale 1ns/1ps
`include "port_pins_defs.svh"

// Two-cycle external access sequencer: address phase then data phase
module ext_bus_seq
	import port_pins_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic is_write,
	input wire addr_t addr,
	input wire byte_t wdata,
	input wire byte_t ad_in,
	output logic busy,
	output logic addr_phase,
	output logic data_phase,
	output logic wr_phase,
	output addr_t addr_hold,
	output byte_t wdata_hold,
	output byte_t rdata,
	output logic rdone
);

	typedef struct packed {
		xmem_state_e st;
		logic wr;
		addr_t a;
		byte_t wd;
		byte_t rd;
		logic done;
	} seq_s;

	seq_s s_r, s_nxt;

	// Next state: start only from idle, two cycles per access
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			XM_IDLE: begin
				if (start) begin
					s_nxt.st = XM_ADDR;
					s_nxt.wr = is_write;
					s_nxt.a = addr;
					s_nxt.wd = wdata;
				end
			end
			XM_ADDR: begin
				s_nxt.st = XM_DATA;
			end
			XM_DATA: begin
				s_nxt.st = XM_IDLE;
				if (!s_r.wr) begin
					s_nxt.rd = ad_in;
					s_nxt.done = 1'b1;
				end
			end
			default: begin
				s_nxt.st = XM_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy = (s_r.st != XM_IDLE);
	assign addr_phase = (s_r.st == XM_ADDR);
	assign data_phase = (s_r.st == XM_DATA);
	assign wr_phase = s_r.wr;
	assign addr_hold = s_r.a;
	assign wdata_hold = s_r.wd;
	assign rdata = s_r.rd;
	assign rdone = s_r.done;

	// Address phase is always followed by the data phase
	addr_then_data_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		addr_phase |=> data_phase && $stable(addr_hold))
		else $error("data phase did not follow address phase");

endmodule

// ---- verilog/port_reset_and_ext_bus_pins.sv ----
`timescale 1ns/1ps
`include "port_pins_defs.svh"

module port_reset_and_ext_bus_pins
	import port_pins_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic por_n,
	input wire logic external_memory_enable,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire addr_t mem_addr,
	input wire byte_t mem_wdata,
	output byte_t mem_rdata,
	output logic mem_rvalid,
	output logic mem_busy,
	input wire byte_t porta_out,
	input wire byte_t porta_dir,
	input wire byte_t porta_pullup,
	output byte_t porta_in,
	input wire byte_t portb_out,
	input wire byte_t portb_dir,
	output byte_t portb_in,
	input wire byte_t portd_out,
	input wire byte_t portd_dir,
	output byte_t portd_in,
	input wire byte_t porte_out,
	input wire byte_t porte_dir,
	output byte_t porte_in,
	input wire byte_t portc_out,
	output byte_t portf_in,
	output byte_t analog_in,
	input wire byte_t low_addr_data_port_pins_i,
	output byte_t low_addr_data_port_pins_o,
	output byte_t low_addr_data_port_pins_oe,
	output byte_t low_addr_data_port_pullup,
	input wire byte_t portb_pins_i,
	output byte_t portb_pins_o,
	output byte_t portb_pins_oe,
	input wire byte_t portd_pins_i,
	output byte_t portd_pins_o,
	output byte_t portd_pins_oe,
	input wire byte_t porte_pins_i,
	output byte_t porte_pins_o,
	output byte_t porte_pins_oe,
	output byte_t high_address_output_pins,
	input wire byte_t input_only_analog_pins,
	output logic ale,
	output logic wr_n,
	output logic rd_n,
	input wire logic program_entry_pin,
	output logic serial_prog_mode
);

	////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		byte_t pc;
		byte_t pf;
	} top_s;

	// Strap state sits on power-on reset only, so it is kept apart
	typedef struct packed {
		logic prog;
		logic por_seen;
	} strap_s;

	top_s s_r, s_nxt;
	strap_s strap_r, strap_nxt;
	logic ext_hit, seq_busy, addr_ph, data_ph, wr_ph, rdone;
	addr_t a_hold;
	byte_t wd_hold, rd_byte;

	// External only when enabled and above internal memory
	function automatic logic is_external(input logic en, input addr_t a);
		return en && (a > `INT_MEM_TOP);
	endfunction

	assign ext_hit = mem_req && is_external(external_memory_enable, mem_addr);

	////////////////////////////////////////////////////////////////
	// External access sequencer

	ext_bus_seq u_seq (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.start(ext_hit),
		.is_write(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.ad_in(low_addr_data_port_pins_i),
		.busy(seq_busy),
		.addr_phase(addr_ph),
		.data_phase(data_ph),
		.wr_phase(wr_ph),
		.addr_hold(a_hold),
		.wdata_hold(wd_hold),
		.rdata(rd_byte),
		.rdone(rdone)
	);

	assign mem_busy = seq_busy;
	assign mem_rdata = rd_byte;
	assign mem_rvalid = rdone;

	// Strobes: latch in address phase, R/W in data phase
	assign ale = external_memory_enable && addr_ph;
	assign wr_n = !(external_memory_enable && data_ph && wr_ph);
	assign rd_n = !(external_memory_enable && data_ph && !wr_ph);

	////////////////////////////////////////////////////////////////
	// Port A: ordinary port or muxed bus; floats whenever reset low

	always_comb begin
		low_addr_data_port_pins_o = porta_out;
		low_addr_data_port_pins_oe = porta_dir;
		low_addr_data_port_pullup = porta_pullup & ~porta_dir;
		if (external_memory_enable && addr_ph) begin
			low_addr_data_port_pins_o = a_hold[7:0];
			low_addr_data_port_pins_oe = 8'hff;
			low_addr_data_port_pullup = 8'h00;
		end else if (external_memory_enable && data_ph) begin
			low_addr_data_port_pins_o = wd_hold;
			low_addr_data_port_pins_oe = wr_ph ? 8'hff : 8'h00;
			low_addr_data_port_pullup = 8'h00;
		end
		// Gated by the reset pin itself so no clock is needed
		if (!rst_n) begin
			low_addr_data_port_pins_oe = 8'h00;
			low_addr_data_port_pullup = 8'h00;
		end
	end

	assign porta_in = low_addr_data_port_pins_i;

	// Other bidirectional ports, asynchronous float on reset
	assign portb_pins_o = portb_out;
	assign portb_pins_oe = rst_n ? portb_dir : 8'h00;
	assign portb_in = portb_pins_i;
	assign portd_pins_o = portd_out;
	assign portd_pins_oe = rst_n ? portd_dir : 8'h00;
	assign portd_in = portd_pins_i;
	assign porte_pins_o = porte_out;
	assign porte_pins_oe = rst_n ? porte_dir : 8'h00;
	assign porte_in = porte_pins_i;

	////////////////////////////////////////////////////////////////
	// Registered state: port C latch, port F sample, program mode

	always_comb begin
		s_nxt = s_r;
		strap_nxt = strap_r;
		// High byte held for the whole access, else ordinary data
		if (external_memory_enable && (addr_ph || data_ph))
			s_nxt.pc = a_hold[15:8];
		else if (external_memory_enable && ext_hit)
			s_nxt.pc = mem_addr[15:8];
		else
			s_nxt.pc = portc_out;
		s_nxt.pf = input_only_analog_pins;
		// Strap sampled once, first edge after power-on release
		if (!strap_r.por_seen) begin
			strap_nxt.por_seen = 1'b1;
			strap_nxt.prog = !program_entry_pin;
		end
	end

	// Port C stays driven through reset: it has no drive enable
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r.pc <= `OUT_PORT_RST;
			s_r.pf <= `IN_PORT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Only power-on re-arms the strap; pin ignored afterwards
	always_ff @(posedge sys_clk or negedge por_n) begin
		if (!por_n) begin
			strap_r.prog <= 1'b0;
			strap_r.por_seen <= 1'b0;
		end else begin
			strap_r <= strap_nxt;
		end
	end

	assign high_address_output_pins = s_r.pc;
	assign portf_in = s_r.pf;
	assign analog_in = input_only_analog_pins;
	assign serial_prog_mode = strap_r.prog;

	////////////////////////////////////////////////////////////////
	// Checks

	float_on_reset_a: assert property (@(posedge sys_clk)
		!rst_n |-> (low_addr_data_port_pins_oe == 8'h00)
		&& (portb_pins_oe == 8'h00) && (portd_pins_oe == 8'h00)
		&& (porte_pins_oe == 8'h00))
		else $error("bidirectional port driven in reset");

	ale_addr_phase_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		ale |-> (low_addr_data_port_pins_o == a_hold[7:0]) ##1 !ale)
		else $error("latch strobe without low address");

	ext_starts_ale_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		(ext_hit && !seq_busy) |=> ale)
		else $error("external access did not strobe latch");

	strobes_excl_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		!(!wr_n && !rd_n) && !(ale && (!wr_n || !rd_n)))
		else $error("strobes overlap");

	internal_quiet_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		(mem_req && mem_addr <= `INT_MEM_TOP && !seq_busy)
		|=> wr_n && rd_n)
		else $error("strobe during internal access");

	disabled_idle_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		!external_memory_enable |-> !ale && wr_n && rd_n)
		else $error("bus strobe while disabled");

	enable_gates_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		(mem_req && !external_memory_enable && !seq_busy) |=> !ale)
		else $error("bus used while disabled");

	high_addr_hold_a: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		(ale && external_memory_enable) |=>
		high_address_output_pins == a_hold[15:8] ##1
		high_address_output_pins == a_hold[15:8])
		else $error("high address not held");

	prog_stable_a: assert property (@(posedge sys_clk)
		disable iff (!por_n)
		strap_r.por_seen |=> $stable(serial_prog_mode))
		else $error("program mode changed after power-on");

	write_cov: cover property (@(posedge sys_clk) !wr_n);
	read_cov: cover property (@(posedge sys_clk) rdone);
	prog_cov: cover property (@(posedge sys_clk) serial_prog_mode);
	reset_cov: cover property (@(posedge sys_clk) !rst_n ##1 rst_n);

endmodule

// ---- test/ext_sram_model.sv ----
`timescale 1ns/1ps
// External SRAM behind an address latch, plus board drive on port A
module ext_sram_model
	import port_pins_pkg::*;
(
	input wire logic sys_clk,
	input wire logic ale,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire byte_t low_addr_data_port_pins_o,
	input wire byte_t low_addr_data_port_pins_oe,
	input wire byte_t high_address_output_pins,
	input wire logic board_en,
	input wire byte_t board_val,
	output byte_t low_addr_data_port_pins_i
);
	byte_t lat_r;
	byte_t mem [0:65535];
	addr_t a;
	byte_t o, oe;

	assign a = {high_address_output_pins, lat_r};
	assign o = low_addr_data_port_pins_o;
	assign oe = low_addr_data_port_pins_oe;

	////////////////////////////////////////////////////////////////
	// Latch takes the low byte while the strobe is high
	always @(posedge sys_clk) begin
		if (ale) lat_r <= o;
		if (!wr_n) mem[a] <= o;
	end

	// Outside a read strobe, undriven bits show board_val when board_en is set, else the inverse of o, never a stale copy
	always @* begin
		if (!rd_n) low_addr_data_port_pins_i = mem[a];
		else if (board_en) low_addr_data_port_pins_i = (o & oe) | (board_val & ~oe);
		else low_addr_data_port_pins_i = (o & oe) | (~o & ~oe);
	end
endmodule

// ---- test/port_reset_and_ext_bus_pins_tb.sv ----
`timescale 1ns/1ps
module port_reset_and_ext_bus_pins_tb;
	import port_pins_pkg::*;
	logic sys_clk = 0, rst_n = 0, por_n = 0, mem_req = 0, mem_we = 0;
	logic external_memory_enable = 0, program_entry_pin = 1, board_en = 1;
	addr_t mem_addr = 0;
	byte_t mem_wdata = 0, porta_out = 0, porta_dir = 0, porta_pullup = 0;
	byte_t portb_out = 0, portb_dir = 0, portd_out = 0, portd_dir = 0;
	byte_t porte_out = 0, porte_dir = 0, portc_out = 0, portb_pins_i = 0;
	byte_t portd_pins_i = 0, porte_pins_i = 0, input_only_analog_pins = 0;
	byte_t board_val = 0, mem_rdata, porta_in, portb_in, portd_in, porte_in;
	byte_t portf_in, analog_in, low_addr_data_port_pins_i;
	byte_t low_addr_data_port_pins_o, low_addr_data_port_pins_oe;
	byte_t low_addr_data_port_pullup, portb_pins_o, portb_pins_oe;
	byte_t portd_pins_o, portd_pins_oe, porte_pins_o, porte_pins_oe;
	byte_t high_address_output_pins;
	logic mem_rvalid, mem_busy, ale, wr_n, rd_n, serial_prog_mode;
	int n_errors = 0, checks = 0;

	port_reset_and_ext_bus_pins uut (
		.sys_clk(sys_clk), .rst_n(rst_n), .por_n(por_n),
		.external_memory_enable(external_memory_enable),
		.mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
		.mem_busy(mem_busy),
		.porta_out(porta_out), .porta_dir(porta_dir),
		.porta_pullup(porta_pullup), .porta_in(porta_in),
		.portb_out(portb_out), .portb_dir(portb_dir),
		.portb_in(portb_in),
		.portd_out(portd_out), .portd_dir(portd_dir),
		.portd_in(portd_in),
		.porte_out(porte_out), .porte_dir(porte_dir),
		.porte_in(porte_in),
		.portc_out(portc_out), .portf_in(portf_in),
		.analog_in(analog_in),
		.low_addr_data_port_pins_i(low_addr_data_port_pins_i),
		.low_addr_data_port_pins_o(low_addr_data_port_pins_o),
		.low_addr_data_port_pins_oe(low_addr_data_port_pins_oe),
		.low_addr_data_port_pullup(low_addr_data_port_pullup),
		.portb_pins_i(portb_pins_i), .portb_pins_o(portb_pins_o),
		.portb_pins_oe(portb_pins_oe),
		.portd_pins_i(portd_pins_i), .portd_pins_o(portd_pins_o),
		.portd_pins_oe(portd_pins_oe),
		.porte_pins_i(porte_pins_i), .porte_pins_o(porte_pins_o),
		.porte_pins_oe(porte_pins_oe),
		.high_address_output_pins(high_address_output_pins),
		.input_only_analog_pins(input_only_analog_pins),
		.ale(ale), .wr_n(wr_n), .rd_n(rd_n),
		.program_entry_pin(program_entry_pin),
		.serial_prog_mode(serial_prog_mode)
	);
	ext_sram_model sram (
		.sys_clk(sys_clk), .ale(ale), .wr_n(wr_n), .rd_n(rd_n),
		.low_addr_data_port_pins_o(low_addr_data_port_pins_o),
		.low_addr_data_port_pins_oe(low_addr_data_port_pins_oe),
		.high_address_output_pins(high_address_output_pins),
		.board_en(board_en), .board_val(board_val),
		.low_addr_data_port_pins_i(low_addr_data_port_pins_i)
	);

	initial forever #5 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////
	// Compare and count
	task chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task wrap_up;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// One access; ext says whether the bus should move
	task xacc(input logic we, input addr_t a, input byte_t d, input logic ext);
		@(posedge sys_clk);
		mem_req <= 1;
		mem_we <= we;
		mem_addr <= a;
		mem_wdata <= d;
		@(posedge sys_clk);
		mem_req <= 0;
		#1;
		chk({ale, mem_busy}, {ext, ext});
		if (ext) chk({low_addr_data_port_pins_oe, low_addr_data_port_pins_o,
			high_address_output_pins}, {8'hff, a[7:0], a[15:8]});
		tick(1);
		chk({ale, wr_n, rd_n}, ext ? {1'b0, !we, we} : 3'b011);
		if (ext) chk(high_address_output_pins, a[15:8]);
		if (ext && we) chk(low_addr_data_port_pins_o, d);
		tick(1);
		chk({mem_rvalid, wr_n, rd_n}, {ext && !we, 2'b11});
		if (ext && !we) chk(mem_rdata, d);
	endtask

	////////////////////////////////////////////////////////////////
	// Plain ports with the bus function off
	task t_ports;
		@(posedge sys_clk);
		porta_out <= 8'h5a;
		porta_dir <= 8'hf0;
		porta_pullup <= 8'hff;
		board_val <= 8'hc3;
		{portb_out, portd_out, porte_out} <= {3{8'ha5}};
		{portb_dir, portd_dir, porte_dir} <= {3{8'hff}};
		{portb_pins_i, portd_pins_i, porte_pins_i} <= {3{8'h3c}};
		portc_out <= 8'h99;
		input_only_analog_pins <= 8'he7;
		tick(2);
		chk({low_addr_data_port_pins_oe, low_addr_data_port_pullup,
			porta_in}, 24'hf00f53);
		chk({portb_pins_oe, portd_pins_oe, porte_pins_oe}, {3{8'hff}});
		chk({portb_pins_o, portd_pins_o, porte_pins_o}, {3{8'ha5}});
		chk({portb_in, portd_in, porte_in}, {3{8'h3c}});
		chk({high_address_output_pins, portf_in, analog_in}, 24'h99e7e7);
		chk({ale, wr_n, rd_n}, 3'b011);
		$display("ports done");
	endtask

	// Reset taken between edges floats the pins at once
	task t_reset;
		#3 rst_n <= 0;
		#1;
		chk({low_addr_data_port_pins_oe, portb_pins_oe}, 16'h0);
		chk({portd_pins_oe, porte_pins_oe}, 16'h0);
		chk(low_addr_data_port_pullup, 8'h00);
		tick(5);
		chk(high_address_output_pins, 8'h00);
		@(posedge sys_clk);
		rst_n <= 1;
		tick(2);
		chk(portb_pins_oe, 8'hff);
		$display("reset done");
	endtask

	task t_xmem;
		xacc(1, 16'h0fff, 8'h11, 0);
		@(posedge sys_clk);
		external_memory_enable <= 1;
		board_en <= 0;
		xacc(1, 16'h12a5, 8'h3c, 1);
		xacc(1, 16'hff00, 8'hc1, 1);
		xacc(0, 16'h12a5, 8'h3c, 1);
		xacc(0, 16'hff00, 8'hc1, 1);
		xacc(0, 16'h0fff, 8'h00, 0);
		xacc(1, 16'h1000, 8'h6b, 1);
		xacc(0, 16'h1000, 8'h6b, 1);
		$display("external bus done");
	endtask

	// Request held while busy is ignored, then taken once idle
	task t_busy;
		@(posedge sys_clk);
		mem_req <= 1;
		mem_we <= 1;
		mem_addr <= 16'h1234;
		mem_wdata <= 8'h77;
		@(posedge sys_clk);
		mem_addr <= 16'h2345;
		mem_wdata <= 8'h88;
		tick(1);
		chk({ale, wr_n, high_address_output_pins}, {2'b00, 8'h12});
		chk(low_addr_data_port_pins_o, 8'h77);
		tick(1);
		chk({mem_busy, ale, wr_n, rd_n}, 4'b0011);
		@(posedge sys_clk);
		mem_req <= 0;
		#1;
		chk({ale, low_addr_data_port_pins_o, high_address_output_pins},
			{1'b1, 8'h45, 8'h23});
		tick(1);
		chk({ale, wr_n, low_addr_data_port_pins_o}, {2'b00, 8'h88});
		tick(1);
		xacc(0, 16'h1234, 8'h77, 1);
		xacc(0, 16'h2345, 8'h88, 1);
		$display("busy refusal done");
	endtask

	task t_prog;
		@(posedge sys_clk);
		por_n <= 0;
		program_entry_pin <= 0;
		repeat (3) @(posedge sys_clk);
		por_n <= 1;
		tick(2);
		chk(serial_prog_mode, 1'b1);
		@(posedge sys_clk);
		program_entry_pin <= 1;
		tick(3);
		chk(serial_prog_mode, 1'b1);
		@(posedge sys_clk);
		por_n <= 0;
		repeat (3) @(posedge sys_clk);
		por_n <= 1;
		tick(2);
		chk(serial_prog_mode, 1'b0);
		$display("programming entry done");
	endtask

	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1;
		por_n <= 1;
		tick(2);
		t_ports;
		t_reset;
		t_xmem;
		t_busy;
		t_prog;
		wrap_up;
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#20000;
		n_errors++;
		wrap_up;
	end
endmodule
